// ==== src/mfi_params.svh ====
`ifndef MFI_PARAMS_SVH
`define MFI_PARAMS_SVH

// register byte offsets
`define MFI_OFF_POL       8'h00
`define MFI_OFF_DBT       8'h04
`define MFI_OFF_MAP       8'h08
`define MFI_OFF_CTRL      8'h0c
`define MFI_OFF_RAW       8'h10
`define MFI_OFF_STAT      8'h14

// reset values
`define MFI_POL_RST       12'h000
`define MFI_DBT_RST       5'h01
`define MFI_MAP_RST       24'h000000
`define MFI_CTRL_RST      16'h0000

// debounce setting range and timing
`define MFI_DBT_MIN       5'h01
`define MFI_DBT_MAX       5'h14
`define MFI_CLK_MHZ       50
`define MFI_DBT_UNIT_MS   2
`define MFI_DBT_UNIT_CYC  (`MFI_DBT_UNIT_MS * 1000 * `MFI_CLK_MHZ)

// function map fields: terminal number 1..12, 0 = unassigned
`define MFI_MAP_F19_LSB   0
`define MFI_MAP_F20_LSB   4
`define MFI_MAP_F21_LSB   8
`define MFI_MAP_F22_LSB   12
`define MFI_MAP_F23_LSB   16
`define MFI_MAP_F24_LSB   20

// control fields
`define MFI_CTRL_CS_LSB   0
`define MFI_CTRL_DIR_LSB  2
`define MFI_CTRL_STOP_BIT 4
`define MFI_CTRL_FQ1_LSB  8
`define MFI_CTRL_FQ2_LSB  12

// command source codes
`define MFI_CS_KEYPAD     2'h0
`define MFI_CS_EXT2W      2'h1
`define MFI_CS_EXT3W      2'h2
`define MFI_CS_COMM       2'h3

// terminal 3 is the low bit of the speed index
`define MFI_SPD_LSB       2
`define MFI_POL_LOCK_MASK 12'h007

`endif

// ==== src/mfi_pkg.sv ====
`default_nettype none
package mfi_pkg;
  typedef enum logic [2:0] {
    program_idle_state     = 3'b001,
    program_run_state      = 3'b010,
    program_download_state = 3'b100
  } mfi_prog_e;
  typedef logic [1:0] mfi_cs_t;
endpackage : mfi_pkg
`default_nettype wire

// ==== src/mfi_debounce.sv ====
`default_nettype none
module mfi_debounce #(
  parameter int CW = 22
) (
  // clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // level in and out
  input  wire logic          in_level,
  input  wire logic [CW-1:0] limit,
  output logic               out_level
);
  import mfi_pkg::*;

  logic          out_r;
  logic          out_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire           differs = in_level != out_r;
  wire           expired = (cnt_r + CW'(1)) >= limit;

  // any return to the held level restarts the count, so short pulses vanish
  assign cnt_nxt   = (!differs || expired) ? '0 : cnt_r + CW'(1);
  assign out_nxt   = (differs && expired) ? in_level : out_r;
  assign out_level = out_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_r <= 1'b1;
      cnt_r <= '0;
    end else begin
      out_r <= out_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  held_full_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(out_r) |-> $past(differs) && ($past(cnt_r) + CW'(1) >= $past(limit)))
    else $error("debounced level changed before the delay ran out");

endmodule // mfi_debounce
`default_nettype wire

// ==== src/mfi_top.sv ====
// What this block does
// - function 19 terminal on: commands from keypad; off: from command-source parameter
// - function 20 terminal on: commands from comm link; off: from command-source parameter
// - function 21 terminal sets direction first, only when direction control is zero
// - function 22 terminal on selects second frequency source, off the first
// - function 23 on while stopped enters run; off returns idle and stops motor
// - function 23 terminal ignored while in program-download state
// - function 24 on while stopped enters download; off returns idle and stops motor
// - function 24 terminal ignored while in program-run state
// - keypad cannot change program state when commands come from external terminals
// - terminals 6..3 form speed index, zero is master frequency
// - polarity register 0..4095, reset zero, bit zero is terminal one
// - polarity bit one means normally closed, inverting the terminal
// - polarity of terminals 1..3 ignored in two- or three-wire terminal mode
// - extension terminals use higher polarity bits
// - terminals active low; raw status reads all ones when idle
`include "mfi_params.svh"
`default_nettype none
module mfi_top #(
  parameter int N_TERM       = 12,
  parameter int DBT_UNIT_CYC = `MFI_DBT_UNIT_CYC
) (
  // ahb-lite slave
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [7:0]          haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic                hready,
  input  wire logic [31:0]         hwdata,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // terminal pins, low means acting
  input  wire logic [N_TERM-1:0]   term_pin,
  // drive and keypad
  input  wire logic                drive_stopped,
  input  wire logic                kp_prog_run,
  input  wire logic                kp_prog_dl,
  input  wire logic                kp_prog_idle,
  // decoded results
  output logic [N_TERM-1:0]        term_active,
  output mfi_pkg::mfi_cs_t         cmd_source,
  output logic                     sel_second_freq,
  output logic [3:0]               freq_source,
  output logic                     dir_override,
  output logic                     dir_reverse,
  output logic [3:0]               speed_index,
  output mfi_pkg::mfi_prog_e       prog_state,
  output logic                     prog_stop_req,
  output logic                     stop_method
);
  import mfi_pkg::*;

  localparam int CW = 22;

  // registers
  logic [N_TERM-1:0] pol_r;
  logic [4:0]        dbt_r;
  logic [23:0]       map_r;
  logic [15:0]       ctrl_r;
  logic              dp_wr_r;
  logic [7:0]        dp_addr_r;
  logic [31:0]       hrdata_r;

  // bus decode
  wire ap_take = hsel && htrans[1] && hready;
  wire wr_pol  = dp_wr_r && dp_addr_r == `MFI_OFF_POL;
  wire wr_dbt  = dp_wr_r && dp_addr_r == `MFI_OFF_DBT;
  wire wr_map  = dp_wr_r && dp_addr_r == `MFI_OFF_MAP;
  wire wr_ctrl = dp_wr_r && dp_addr_r == `MFI_OFF_CTRL;
  // out-of-range debounce settings are dropped so the delay never reaches zero
  wire dbt_ok  = hwdata[4:0] >= `MFI_DBT_MIN && hwdata[4:0] <= `MFI_DBT_MAX;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_wr_r   <= ap_take && hwrite;
      dp_addr_r <= ap_take ? haddr : dp_addr_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pol_r  <= N_TERM'(`MFI_POL_RST);
      dbt_r  <= `MFI_DBT_RST;
      map_r  <= `MFI_MAP_RST;
      ctrl_r <= `MFI_CTRL_RST;
    end else begin
      if (wr_pol) pol_r <= hwdata[N_TERM-1:0];
      if (wr_dbt && dbt_ok) dbt_r <= hwdata[4:0];
      if (wr_map) map_r <= hwdata[23:0];
      if (wr_ctrl) ctrl_r <= hwdata[15:0];
    end
  end

  // fields
  wire mfi_cs_t cs_param = ctrl_r[`MFI_CTRL_CS_LSB +: 2];
  wire [1:0]    dir_ctl  = ctrl_r[`MFI_CTRL_DIR_LSB +: 2];
  wire [3:0]    fq1      = ctrl_r[`MFI_CTRL_FQ1_LSB +: 4];
  wire [3:0]    fq2      = ctrl_r[`MFI_CTRL_FQ2_LSB +: 4];

  // pin synchroniser, idle high
  logic [N_TERM-1:0] sync1_r;
  logic [N_TERM-1:0] sync2_r;
  logic [N_TERM-1:0] deb;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= term_pin;
      sync2_r <= sync1_r;
    end
  end

  wire [CW-1:0] dbt_limit = CW'(dbt_r) * CW'(DBT_UNIT_CYC);

  genvar gi;
  generate
    for (gi = 0; gi < N_TERM; gi++) begin : g_deb
      mfi_debounce #(.CW(CW)) u_deb (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_level  (sync2_r[gi]),
        .limit     (dbt_limit),
        .out_level (deb[gi])
      );
    end
  endgenerate

  // polarity taken from the parameter, not the override, to avoid a loop through the terminals
  wire ext_param = cs_param == `MFI_CS_EXT2W || cs_param == `MFI_CS_EXT3W;
  wire [N_TERM-1:0] pol_eff = ext_param ? (pol_r & ~N_TERM'(`MFI_POL_LOCK_MASK)) : pol_r;
  wire [N_TERM-1:0] act = ~deb ^ pol_eff;
  wire [15:0] act_pad = 16'({act, 1'b0});

  function automatic logic fn_on(input logic [3:0] num, input logic [15:0] vec);
    fn_on = num != 4'h0 && 32'(num) <= N_TERM && vec[num];
  endfunction

  wire f19_on = fn_on(map_r[`MFI_MAP_F19_LSB +: 4], act_pad);
  wire f20_on = fn_on(map_r[`MFI_MAP_F20_LSB +: 4], act_pad);
  wire f21_in = map_r[`MFI_MAP_F21_LSB +: 4] != 4'h0;
  wire f21_on = fn_on(map_r[`MFI_MAP_F21_LSB +: 4], act_pad);
  wire f22_on = fn_on(map_r[`MFI_MAP_F22_LSB +: 4], act_pad);
  wire run_on = fn_on(map_r[`MFI_MAP_F23_LSB +: 4], act_pad);
  wire dl_on  = fn_on(map_r[`MFI_MAP_F24_LSB +: 4], act_pad);

  // keypad wins if both override terminals act at once
  wire mfi_cs_t cs_eff = f19_on ? `MFI_CS_KEYPAD : f20_on ? `MFI_CS_COMM : cs_param;
  wire ext_eff = cs_eff == `MFI_CS_EXT2W || cs_eff == `MFI_CS_EXT3W;

  // program controller
  mfi_prog_e state_r;
  mfi_prog_e state_nxt;
  logic      run_d_r;
  logic      dl_d_r;
  logic      stop_r;
  wire run_rise = run_on && !run_d_r;
  wire run_fall = !run_on && run_d_r;
  wire dl_rise  = dl_on && !dl_d_r;
  wire dl_fall  = !dl_on && dl_d_r;
  wire kp_ok    = !ext_eff;
  wire to_idle  = state_nxt == program_idle_state && state_r != program_idle_state;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      program_idle_state: begin
        if (drive_stopped && run_rise) state_nxt = program_run_state;
        else if (drive_stopped && dl_rise) state_nxt = program_download_state;
        else if (drive_stopped && kp_ok && kp_prog_run) state_nxt = program_run_state;
        else if (drive_stopped && kp_ok && kp_prog_dl) state_nxt = program_download_state;
      end
      program_run_state: begin
        // the download terminal is not looked at here
        if (run_fall || (kp_ok && kp_prog_idle)) state_nxt = program_idle_state;
      end
      program_download_state: begin
        // the run terminal is not looked at here
        if (dl_fall || (kp_ok && kp_prog_idle)) state_nxt = program_idle_state;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= program_idle_state;
      run_d_r <= 1'b0;
      dl_d_r  <= 1'b0;
      stop_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      run_d_r <= run_on;
      dl_d_r  <= dl_on;
      stop_r  <= to_idle;
    end
  end

  // registered results
  logic [N_TERM-1:0] act_r;
  mfi_cs_t           cs_r;
  logic              sel2_r;
  logic [3:0]        fqs_r;
  logic              dirv_r;
  logic              dirr_r;
  logic [3:0]        spd_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_r  <= '0;
      cs_r   <= `MFI_CS_KEYPAD;
      sel2_r <= 1'b0;
      fqs_r  <= 4'h0;
      dirv_r <= 1'b0;
      dirr_r <= 1'b0;
      spd_r  <= 4'h0;
    end else begin
      act_r  <= act;
      cs_r   <= cs_eff;
      sel2_r <= f22_on;
      fqs_r  <= f22_on ? fq2 : fq1;
      dirv_r <= f21_in && dir_ctl == 2'h0;
      dirr_r <= f21_on;
      spd_r  <= act[`MFI_SPD_LSB +: 4];
    end
  end

  // read data is latched in the address phase; zero wait states
  wire [31:0] rd_mux =
    haddr == `MFI_OFF_POL  ? 32'(pol_r) :
    haddr == `MFI_OFF_DBT  ? 32'(dbt_r) :
    haddr == `MFI_OFF_MAP  ? 32'(map_r) :
    haddr == `MFI_OFF_CTRL ? 32'(ctrl_r) :
    haddr == `MFI_OFF_RAW  ? 32'(deb) :
    haddr == `MFI_OFF_STAT ? {10'h000, spd_r, cs_r, 1'b0, state_r, 12'(act_r)} :
    32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_r <= 32'h00000000;
    else if (ap_take && !hwrite) hrdata_r <= rd_mux;
  end

  assign hrdata          = hrdata_r;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign term_active     = act_r;
  assign cmd_source      = cs_r;
  assign sel_second_freq = sel2_r;
  assign freq_source     = fqs_r;
  assign dir_override    = dirv_r;
  assign dir_reverse     = dirr_r;
  assign speed_index     = spd_r;
  assign prog_state      = state_r;
  assign prog_stop_req   = stop_r;
  assign stop_method     = ctrl_r[`MFI_CTRL_STOP_BIT];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  kp_override_a: assert property (f19_on |=> cmd_source == `MFI_CS_KEYPAD)
    else $error("keypad override not applied");
  comm_override_a: assert property (!f19_on && f20_on |=> cmd_source == `MFI_CS_COMM)
    else $error("comm override not applied");
  dir_priority_a: assert property (f21_in && dir_ctl == 2'h0 |=> dir_override && dir_reverse == $past(f21_on))
    else $error("direction terminal not honoured");
  freq_select_a: assert property (##1 freq_source == ($past(f22_on) ? $past(fq2) : $past(fq1)))
    else $error("wrong frequency source");
  run_enter_a: assert property (state_r == program_idle_state && drive_stopped && run_rise
    |=> prog_state == program_run_state)
    else $error("run terminal did not start program");
  // the stop request rises on the same edge that enters idle and lasts one cycle
  run_exit_a: assert property (state_r == program_run_state && run_fall
    |=> prog_state == program_idle_state && prog_stop_req && !$past(prog_stop_req) ##1 !prog_stop_req)
    else $error("run release did not stop program");
  dl_enter_a: assert property (state_r == program_idle_state && drive_stopped && dl_rise && !run_rise
    |=> prog_state == program_download_state)
    else $error("download terminal did not start program");
  dl_exit_a: assert property (state_r == program_download_state && dl_fall
    |=> prog_state == program_idle_state && prog_stop_req ##1 !prog_stop_req)
    else $error("download release did not stop program");
  dbt_range_a: assert property (dbt_r >= `MFI_DBT_MIN && dbt_r <= `MFI_DBT_MAX)
    else $error("debounce setting out of range");
  dl_blocks_run_a: assert property (state_r == program_download_state |=> prog_state != program_run_state)
    else $error("run entered from download");
  run_blocks_dl_a: assert property (state_r == program_run_state |=> prog_state != program_download_state)
    else $error("download entered from run");
  kp_reject_a: assert property (ext_eff && state_r == program_idle_state && !run_rise && !dl_rise
    |=> $stable(prog_state))
    else $error("keypad changed program state under terminal control");
  speed_index_a: assert property (##1 speed_index == $past(act[5:2]))
    else $error("speed index does not match terminals");
  pol_lock_a: assert property (ext_param |-> act[2:0] == ~deb[2:0])
    else $error("locked terminals inverted");

  cv_run: cover property (state_r == program_idle_state ##1 state_r == program_run_state ##[1:20] prog_stop_req);
  cv_dl: cover property (state_r == program_download_state ##1 state_r == program_idle_state);
  cv_speed: cover property (speed_index == 4'hf);
  cv_comm: cover property (cmd_source == `MFI_CS_COMM && f20_on);

endmodule // mfi_top
`default_nettype wire

// ==== tb/mfi_switch_model.sv ====
`default_nettype none
module mfi_switch_model (
  // clock
  input  wire logic        hclk,
  // wanted contact action, contact type, forced bounce
  input  wire logic [11:0] act,
  input  wire logic [11:0] nc,
  input  wire logic [11:0] glitch,
  // pins towards the block
  output logic [11:0]      term_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // a closed normally-open contact pulls low; normally-closed inverts that
  always @(posedge hclk) begin
    term_pin <= ~(act ^ nc) ^ glitch;
  end
endmodule // mfi_switch_model
`default_nettype wire

// ==== tb/multifunction_input_terminal_logic_bench.sv ====
`default_nettype none
module multifunction_input_terminal_logic_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mfi_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd, ctl;
  logic [11:0] act, nc, glitch, pin, term_active, a, la, p;
  logic drive_stopped, kp_prog_run, kp_prog_dl, kp_prog_idle;
  logic sel_second_freq, dir_override, dir_reverse, prog_stop_req, stop_method;
  logic [3:0] freq_source, speed_index;
  mfi_cs_t cmd_source, cs;
  mfi_prog_e prog_state;
  int n_errors, checks_done, cyc, dbt, n_stop, es, seed;
  assign hready = hreadyout;

  mfi_switch_model sw (.hclk(hclk), .act(act), .nc(nc), .glitch(glitch), .term_pin(pin));
  mfi_top #(.N_TERM(12), .DBT_UNIT_CYC(4)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .term_pin(pin), .drive_stopped(drive_stopped), .kp_prog_run(kp_prog_run),
    .kp_prog_dl(kp_prog_dl), .kp_prog_idle(kp_prog_idle), .term_active(term_active),
    .cmd_source(cmd_source), .sel_second_freq(sel_second_freq), .freq_source(freq_source),
    .dir_override(dir_override), .dir_reverse(dir_reverse), .speed_index(speed_index),
    .prog_state(prog_state), .prog_stop_req(prog_stop_req), .stop_method(stop_method));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // cut a hang short; the whole run needs well under this
  always @(posedge hclk) begin
    cyc++;
    if (prog_stop_req === 1'b1) n_stop <= n_stop + 1;
    if (cyc == 40000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // single ahb-lite word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp, input string nm);
    xfer(1'b0, ad, 32'h0);
    chk(nm, exp, rd);
    chk("hreadyout hresp", 32'h2, {30'h0, hreadyout, hresp});
  endtask

  task automatic settle();
    repeat (dbt * 4 + 10) @(posedge hclk);
  endtask

  task automatic step(input logic [11:0] v, input mfi_prog_e s);
    act <= v;
    settle();
    chk("prog_state", s, prog_state);
    chk("stop pulses", es, n_stop);
  endtask

  task automatic kp(input int w, input mfi_prog_e s);
    if (w == 0) kp_prog_run <= 1'b1;
    if (w == 1) kp_prog_dl <= 1'b1;
    if (w == 2) kp_prog_idle <= 1'b1;
    @(posedge hclk);
    kp_prog_run <= 1'b0;
    kp_prog_dl <= 1'b0;
    kp_prog_idle <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("prog_state kp", s, prog_state);
    chk("stop pulses kp", es, n_stop);
  endtask

  // logical level seen by the decoder; terminals 1..3 ignore polarity in 2/3-wire mode
  function automatic logic [11:0] exp_act(logic [11:0] x, logic [11:0] n, logic [11:0] pl, mfi_cs_t c);
    logic [11:0] ep;
    ep = (c == 2'h1 || c == 2'h2) ? (pl & 12'hff8) : pl;
    return x ^ n ^ ep;
  endfunction

  initial begin
    {hresetn, hsel, hwrite, kp_prog_run, kp_prog_dl, kp_prog_idle, drive_stopped} = 7'h00;
    {haddr, htrans, hwdata} = 42'h0;
    hsize = 3'h2;
    {act, nc, glitch} = 36'h0;
    {n_errors, checks_done, cyc, n_stop, es} = 0;
    dbt = 1;
    seed = 32'hffb4e1c1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(8'h00, 32'h0, "pol reset");
    rdc(8'h04, 32'h1, "dbt reset");
    rdc(8'h08, 32'h0, "map reset");
    rdc(8'h0c, 32'h0, "ctrl reset");
    rdc(8'h10, 32'hfff, "raw idle");
    rdc(8'h18, 32'h0, "unmapped");
    xfer(1'b1, 8'h00, 32'hffffffff);
    rdc(8'h00, 32'hfff, "pol width");
    xfer(1'b1, 8'h08, 32'h00cba987);
    for (int i = 0; i < 16; i++) begin
      a = (i == 0) ? 12'h000 : (i == 1) ? 12'h03c : 12'($random(seed)) & 12'h3ff;
      p = 12'($random(seed));
      ctl = ($random(seed) & 32'h0000ff1c) | (i % 4);
      cs = ctl[1:0];
      xfer(1'b1, 8'h00, {20'h0, p});
      xfer(1'b1, 8'h0c, ctl);
      act <= a;
      nc <= (i < 2) ? p : 12'($random(seed));
      settle();
      la = exp_act(a, nc, p, cs);
      chk("term_active", la, term_active);
      chk("cmd_source", la[6] ? 2'h0 : la[7] ? 2'h3 : cs, cmd_source);
      chk("speed_index", la[5:2], speed_index);
      chk("sel_second", la[9], sel_second_freq);
      chk("freq_source", la[9] ? ctl[15:12] : ctl[11:8], freq_source);
      chk("dir_override", ctl[3:2] == 2'h0, dir_override);
      chk("dir_reverse", la[8], dir_reverse);
      chk("stop_method", ctl[4], stop_method);
      rdc(8'h10, {20'h0, ~(a ^ nc)}, "raw");
      rdc(8'h14, {10'h0, la[5:2], la[6] ? 2'h0 : la[7] ? 2'h3 : cs, 4'h1, la}, "stat");
    end
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b1, 8'h0c, 32'h0);
    act <= 12'h0;
    nc <= 12'h0;
    xfer(1'b1, 8'h04, 32'h3);
    dbt = 3;
    settle();
    glitch <= 12'h004;
    repeat (9) @(posedge hclk);
    glitch <= 12'h0;
    settle();
    chk("short pulse", 12'h0, term_active);
    act <= 12'h004;
    repeat (9) @(posedge hclk);
    chk("before delay", 12'h0, term_active);
    settle();
    chk("after delay", 12'h004, term_active);
    xfer(1'b1, 8'h04, 32'h15);
    rdc(8'h04, 32'h3, "dbt over");
    xfer(1'b1, 8'h04, 32'h0);
    rdc(8'h04, 32'h3, "dbt zero");
    xfer(1'b1, 8'h04, 32'h14);
    rdc(8'h04, 32'h14, "dbt max");
    xfer(1'b1, 8'h04, 32'h1);
    dbt = 1;
    drive_stopped <= 1'b1;
    step(12'h000, program_idle_state);
    step(12'h400, program_run_state);
    step(12'hc00, program_run_state);
    step(12'h400, program_run_state);
    es++;
    step(12'h000, program_idle_state);
    step(12'h800, program_download_state);
    step(12'hc00, program_download_state);
    step(12'h800, program_download_state);
    es++;
    step(12'h000, program_idle_state);
    drive_stopped <= 1'b0;
    step(12'h400, program_idle_state);
    step(12'h000, program_idle_state);
    drive_stopped <= 1'b1;
    kp(0, program_run_state);
    es++;
    kp(2, program_idle_state);
    kp(1, program_download_state);
    es++;
    kp(2, program_idle_state);
    xfer(1'b1, 8'h0c, 32'h1);
    kp(0, program_idle_state);
    step(12'h040, program_idle_state);
    kp(0, program_run_state);
    es++;
    kp(2, program_idle_state);
    print_verdict();
  end
endmodule // multifunction_input_terminal_logic_bench
`default_nettype wire
